// File: verilog/nvm_port_pkg.sv
/*
 * Constants for the parallel nonvolatile programming port.
 * Assumes one 50 MHz clock; pins already synchronous to it.
 */
// Contract
// - EEPROM is paged; latched buffer bytes are programmed together as one page.
// - Program pulse with select A low starts EEPROM page write; ready/busy goes low.
// - Program read command drives word low byte (select A 0) or high byte (1).
// - EEPROM read command drives addressed byte while output enable low, select A 0.
// - Lock write programs every lock bit whose data bit is 0.
// - With both lock level bits programmed, boot lock bits cannot be programmed.
// - Lock bits return unprogrammed only through chip erase.
// - Fuse/lock read: selects 00 low, 11 high, 10 extended, 01 lock bits.
// - Signature read: low address 0 to 2 selects signature byte with select A 0.
// - Signature read at address 0 with select A 1 gives calibration byte.
// - Chip erase sets all program and EEPROM locations to FF.
// - Load strobe with type pins: 00 address, 01 data, 10 command, 11 idle.
// - During loads select A picks low (0) or high (1) byte.
// - Loaded command and address are kept across operations.
`default_nettype none

package nvm_port_pkg;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
	localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
	localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
	localparam logic [7:0] CMD_WRITE_PROG = 8'h10;
	localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
	localparam logic [7:0] CMD_READ_SIG = 8'h08;
	localparam logic [7:0] CMD_READ_FUSE = 8'h04;
	localparam logic [7:0] CMD_READ_PROG = 8'h02;
	localparam logic [7:0] CMD_READ_EEPROM = 8'h03;
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [1:0] LOAD_ADDR = 2'h0;
	localparam logic [1:0] LOAD_DATA = 2'h1;
	localparam logic [1:0] LOAD_CMD = 2'h2;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] FUSE_LOW_RESET = 8'hFF;
	localparam logic [7:0] FUSE_HIGH_RESET = 8'hFF;
	localparam logic [7:0] FUSE_EXT_RESET = 8'hFF;
	localparam logic [7:0] LOCK_RESET = 8'hFF;
	localparam int LOCK_LB1_POS = 0;
	localparam int LOCK_LB2_POS = 1;
	localparam logic [7:0] BOOT_LOCK_MASK = 8'h3C;
	localparam logic [7:0] SIG_MAX_ADDR = 8'h02;
	localparam int CLOCK_HZ = 50000000;
	localparam int WRITE_TIME_US = 20;
	localparam int WRITE_CYCLES = (CLOCK_HZ / 1000000) * WRITE_TIME_US;
	localparam int EEPROM_PAGE_BYTES = 8;

	typedef enum logic [2:0] {
		JOB_NONE_TYPE_UNUSED,
		JOB_EEPROM,
		JOB_PROG,
		JOB_FUSE,
		JOB_LOCK,
		JOB_ERASE
	} job_type;
endpackage : nvm_port_pkg

`default_nettype wire

// File: verilog/busy_timer.sv
/*
 * Self-timed write duration counter driving busy.
 * Assumes a start pulse only while idle.
 */
`default_nettype none

module busy_timer
	import nvm_port_pkg::*;
#(
	parameter int CYCLES = WRITE_CYCLES
) (
	input wire logic clock_in,
	input wire logic srst_in,
	input wire logic start_in,
	output logic busy_out,
	output logic done_out
);
	logic [23:0] count_q;
	logic [23:0] count_d;
	wire running = count_q != 24'h000000;

	assign count_d = start_in ? 24'(CYCLES) : (running ? count_q - 24'h000001 : count_q);
	assign busy_out = running;
	assign done_out = count_q == 24'h000001;

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			count_q <= 24'h000000;
		end else begin
			count_q <= count_d;
		end
	end
endmodule : busy_timer

`default_nettype wire

// File: verilog/page_buffer.sv
/*
 * EEPROM page buffer with per-byte valid bits.
 * Assumes the write index lies within one page.
 */
`default_nettype none

module page_buffer
	import nvm_port_pkg::*;
#(
	parameter int BYTES = EEPROM_PAGE_BYTES
) (
	input wire logic clock_in,
	input wire logic srst_in,
	input wire logic latch_in,
	input wire logic [$clog2(BYTES)-1:0] index_in,
	input wire logic [7:0] data_in,
	input wire logic clear_in,
	input wire logic [$clog2(BYTES)-1:0] read_index_in,
	output logic [7:0] read_data_out,
	output logic read_valid_out
);
	logic [7:0] bytes_q [BYTES];
	logic [BYTES-1:0] valid_q;

	assign read_data_out = bytes_q[read_index_in];
	assign read_valid_out = valid_q[read_index_in];

	always_ff @(posedge clock_in) begin
		if (latch_in) begin
			bytes_q[index_in] <= data_in;
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in || clear_in) begin
			valid_q <= '0;
		end else if (latch_in) begin
			valid_q[index_in] <= 1'b1;
		end
	end
endmodule : page_buffer

`default_nettype wire

// File: verilog/nvm_prog_port.sv
/*
 * Parallel programming port: command/address/data loading, paged EEPROM,
 * program memory, fuse, lock, signature and calibration access.
 * Assumes pins are synchronous; strobes arrive as levels and are edge-detected here.
 */
`default_nettype none

module nvm_prog_port
	import nvm_port_pkg::*;
#(
	parameter int PROG_WORDS = 65536,
	parameter int EEPROM_BYTES = 4096,
	parameter int PAGE_BYTES = EEPROM_PAGE_BYTES,
	parameter int PROG_PAGE_WORDS = 128,
	parameter int WRITE_TICKS = WRITE_CYCLES,
	parameter logic [7:0] SIG_BYTE0 = 8'h5A,
	parameter logic [7:0] SIG_BYTE1 = 8'h5A,
	parameter logic [7:0] SIG_BYTE2 = 8'h5A,
	parameter logic [7:0] CALIBRATION = 8'h80
) (
	input wire logic clock_in,
	input wire logic srst_in,
	input wire logic load_strobe_clock_in,
	input wire logic load_type_hi_in,
	input wire logic load_type_lo_in,
	input wire logic byte_select_a_in,
	input wire logic byte_select_b_in,
	input wire logic page_latch_strobe_in,
	input wire logic write_pulse_n_in,
	input wire logic output_enable_n_in,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_out,
	output logic ready_busy_flag_out,
	output logic [7:0] fuse_low_out,
	output logic [7:0] fuse_high_out,
	output logic [7:0] fuse_ext_out,
	output logic [7:0] lock_bits_out
);
	localparam int EA = $clog2(EEPROM_BYTES);
	localparam int PA = $clog2(PROG_WORDS);
	localparam int PB = $clog2(PAGE_BYTES);
	localparam int PW = $clog2(PROG_PAGE_WORDS);

	logic [7:0] eeprom_q [EEPROM_BYTES];
	logic [15:0] prog_q [PROG_WORDS];
	logic [15:0] prog_buf_q [PROG_PAGE_WORDS];
	logic [7:0] cmd_q;
	logic [7:0] addr_lo_q;
	logic [7:0] addr_hi_q;
	logic [7:0] data_lo_q;
	logic [7:0] data_hi_q;
	logic [7:0] fuse_low_q;
	logic [7:0] fuse_high_q;
	logic [7:0] fuse_ext_q;
	logic [7:0] lock_q;
	logic [7:0] job_data_q;
	logic [1:0] job_sel_q;
	job_type job_q;
	logic strobe_prev_q;
	logic latch_prev_q;
	logic wr_prev_q;
	logic [7:0] data_out_q;
	logic [EA:0] erase_idx_q;
	logic erasing_q;
	logic [PB:0] copy_idx_q;
	logic copying_q;

	// Edge detection of the programmer strobes
	wire strobe_rise = load_strobe_clock_in && !strobe_prev_q;
	wire latch_rise = page_latch_strobe_in && !latch_prev_q;
	wire wr_fall = !write_pulse_n_in && wr_prev_q;
	wire [1:0] load_type = {load_type_hi_in, load_type_lo_in};
	wire [15:0] full_addr = {addr_hi_q, addr_lo_q};
	wire [EA-1:0] ee_addr = EA'(full_addr);
	wire [PA-1:0] pg_addr = PA'(full_addr);
	wire [PB-1:0] ee_index = ee_addr[PB-1:0];
	wire timer_busy;
	wire timer_done;
	wire busy = timer_busy || erasing_q || copying_q;
	wire [PB-1:0] copy_index = copy_idx_q[PB-1:0];
	wire [7:0] buf_byte;
	wire buf_valid;
	wire [EA-1:0] copy_addr = {ee_addr[EA-1:PB], copy_index};
	wire lock_mode3 = !lock_q[LOCK_LB1_POS] && !lock_q[LOCK_LB2_POS];

	// Start only when idle, so pulses during busy are dropped
	wire start_ok = wr_fall && !busy;
	wire start_ee = start_ok && cmd_q == CMD_WRITE_EEPROM && !byte_select_a_in;
	wire start_pg = start_ok && cmd_q == CMD_WRITE_PROG;
	wire start_fuse = start_ok && cmd_q == CMD_WRITE_FUSE;
	wire start_lock = start_ok && cmd_q == CMD_WRITE_LOCK;
	wire start_erase = start_ok && cmd_q == CMD_CHIP_ERASE;
	wire start_any = start_ee || start_pg || start_fuse || start_lock || start_erase;

	// Lock write may only clear bits; boot bits frozen in mode 3
	wire [7:0] lock_prog_mask = lock_mode3 ? ~BOOT_LOCK_MASK : 8'hFF;
	wire [7:0] lock_next = lock_q & (job_data_q | ~lock_prog_mask);

	busy_timer #(
		.CYCLES(WRITE_TICKS)
	) u_timer (
		.clock_in(clock_in),
		.srst_in(srst_in),
		.start_in(start_any),
		.busy_out(timer_busy),
		.done_out(timer_done)
	);

	page_buffer #(
		.BYTES(PAGE_BYTES)
	) u_ee_buf (
		.clock_in(clock_in),
		.srst_in(srst_in),
		.latch_in(latch_rise && cmd_q == CMD_WRITE_EEPROM && !busy),
		.index_in(ee_index),
		.data_in(data_lo_q),
		.clear_in(copying_q && copy_idx_q == (PB+1)'(PAGE_BYTES - 1)),
		.read_index_in(copy_index),
		.read_data_out(buf_byte),
		.read_valid_out(buf_valid)
	);

	assign ready_busy_flag_out = !busy;
	assign data_oe_out = !output_enable_n_in;
	assign data_out = data_out_q;
	assign fuse_low_out = fuse_low_q;
	assign fuse_high_out = fuse_high_q;
	assign fuse_ext_out = fuse_ext_q;
	assign lock_bits_out = lock_q;

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			strobe_prev_q <= 1'b0;
			latch_prev_q <= 1'b0;
			wr_prev_q <= 1'b1;
		end else begin
			strobe_prev_q <= load_strobe_clock_in;
			latch_prev_q <= page_latch_strobe_in;
			wr_prev_q <= write_pulse_n_in;
		end
	end

	// Loaded values stay until overwritten
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			cmd_q <= CMD_NOP;
			addr_lo_q <= 8'h00;
			addr_hi_q <= 8'h00;
			data_lo_q <= 8'hFF;
			data_hi_q <= 8'hFF;
		end else if (strobe_rise) begin
			unique case (load_type)
				LOAD_ADDR: begin
					if (byte_select_a_in) begin
						addr_hi_q <= data_in;
					end else begin
						addr_lo_q <= data_in;
					end
				end
				LOAD_DATA: begin
					if (byte_select_a_in) begin
						data_hi_q <= data_in;
					end else begin
						data_lo_q <= data_in;
					end
				end
				LOAD_CMD: cmd_q <= data_in;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (latch_rise && cmd_q == CMD_WRITE_PROG && !busy) begin
			prog_buf_q[pg_addr[PW-1:0]] <= {data_hi_q, data_lo_q};
		end
	end

	// Job capture at program pulse
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			job_q <= JOB_NONE_TYPE_UNUSED;
			job_data_q <= 8'hFF;
			job_sel_q <= 2'h0;
		end else if (start_any) begin
			job_data_q <= data_lo_q;
			job_sel_q <= {byte_select_b_in, byte_select_a_in};
			if (start_ee) begin
				job_q <= JOB_EEPROM;
			end else if (start_pg) begin
				job_q <= JOB_PROG;
			end else if (start_fuse) begin
				job_q <= JOB_FUSE;
			end else if (start_lock) begin
				job_q <= JOB_LOCK;
			end else begin
				job_q <= JOB_ERASE;
			end
		end else if (timer_done) begin
			job_q <= JOB_NONE_TYPE_UNUSED;
		end
	end

	// Fuse and lock commit when the timed write ends
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			fuse_low_q <= FUSE_LOW_RESET;
			fuse_high_q <= FUSE_HIGH_RESET;
			fuse_ext_q <= FUSE_EXT_RESET;
			lock_q <= LOCK_RESET;
		end else if (timer_done && job_q == JOB_FUSE) begin
			unique case (job_sel_q)
				2'h1: fuse_high_q <= job_data_q;
				2'h2: fuse_ext_q <= job_data_q;
				default: fuse_low_q <= job_data_q;
			endcase
		end else if (timer_done && job_q == JOB_LOCK) begin
			lock_q <= lock_next;
		end else if (erasing_q && erase_idx_q == (EA+1)'(EEPROM_BYTES)) begin
			lock_q <= LOCK_RESET;
		end
	end

	// Page copy after EEPROM timer, erase sweep after erase timer
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			copying_q <= 1'b0;
			copy_idx_q <= '0;
			erasing_q <= 1'b0;
			erase_idx_q <= '0;
		end else begin
			if (timer_done && job_q == JOB_EEPROM) begin
				copying_q <= 1'b1;
				copy_idx_q <= '0;
			end else if (copying_q) begin
				copying_q <= copy_idx_q != (PB+1)'(PAGE_BYTES - 1);
				copy_idx_q <= copy_idx_q + (PB+1)'(1);
			end
			if (timer_done && job_q == JOB_ERASE) begin
				erasing_q <= 1'b1;
				erase_idx_q <= '0;
			end else if (erasing_q) begin
				erasing_q <= erase_idx_q != (EA+1)'(EEPROM_BYTES);
				erase_idx_q <= erase_idx_q + (EA+1)'(1);
			end
		end
	end

	// Memory arrays; erase sweeps the EEPROM by index, program array is set to FF in one cycle by a loop
	always_ff @(posedge clock_in) begin
		if (copying_q && buf_valid) begin
			eeprom_q[copy_addr] <= buf_byte;
		end else if (erasing_q && erase_idx_q < (EA+1)'(EEPROM_BYTES)) begin
			eeprom_q[erase_idx_q[EA-1:0]] <= ERASED_BYTE;
		end
	end

	always_ff @(posedge clock_in) begin
		if (timer_done && job_q == JOB_PROG) begin
			for (int i = 0; i < PROG_PAGE_WORDS; i++) begin
				prog_q[{pg_addr[PA-1:PW], PW'(i)}] <= prog_buf_q[i];
			end
		end else if (timer_done && job_q == JOB_ERASE) begin
			for (int i = 0; i < PROG_WORDS; i++) begin
				prog_q[i] <= {ERASED_BYTE, ERASED_BYTE};
			end
		end
	end

	// Read data path
	wire [15:0] prog_word = prog_q[pg_addr];
	wire [7:0] sig_byte = addr_lo_q == 8'h00 ? SIG_BYTE0 :
		(addr_lo_q == 8'h01 ? SIG_BYTE1 : SIG_BYTE2);
	wire [1:0] fuse_sel = {byte_select_b_in, byte_select_a_in};
	logic [7:0] read_d;

	always_comb begin
		read_d = 8'hFF;
		unique case (cmd_q)
			CMD_READ_PROG: read_d = byte_select_a_in ? prog_word[15:8] : prog_word[7:0];
			CMD_READ_EEPROM: read_d = eeprom_q[ee_addr];
			CMD_READ_FUSE: begin
				unique case (fuse_sel)
					2'h0: read_d = fuse_low_q;
					2'h3: read_d = fuse_high_q;
					2'h2: read_d = fuse_ext_q;
					default: read_d = lock_q;
				endcase
			end
			CMD_READ_SIG: begin
				if (byte_select_a_in) begin
					read_d = addr_lo_q == 8'h00 ? CALIBRATION : 8'hFF;
				end else if (addr_lo_q <= SIG_MAX_ADDR) begin
					read_d = sig_byte;
				end
			end
			default: read_d = 8'hFF;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			data_out_q <= 8'hFF;
		end else begin
			data_out_q <= read_d;
		end
	end
endmodule : nvm_prog_port

`default_nettype wire

// File: dv/nvm_port_properties.sv
/* Pin-level checker for the parallel programming port.
   Assumes it is bound onto nvm_prog_port and shares its single clock. */
`default_nettype none
module nvm_port_properties
	import nvm_port_pkg::*;
#(
	parameter int WRITE_TICKS = WRITE_CYCLES,
	parameter int EEPROM_BYTES = 4096,
	parameter int PAGE_BYTES = EEPROM_PAGE_BYTES,
	parameter logic [7:0] SIG_BYTE0 = 8'h5A,
	parameter logic [7:0] SIG_BYTE1 = 8'h5A,
	parameter logic [7:0] SIG_BYTE2 = 8'h5A,
	parameter logic [7:0] CALIBRATION = 8'h80
) (
	input wire logic clock_in,
	input wire logic srst_in,
	input wire logic load_strobe_clock_in,
	input wire logic load_type_hi_in,
	input wire logic load_type_lo_in,
	input wire logic byte_select_a_in,
	input wire logic byte_select_b_in,
	input wire logic write_pulse_n_in,
	input wire logic output_enable_n_in,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic data_oe_out,
	input wire logic ready_busy_flag_out,
	input wire logic [7:0] fuse_low_out,
	input wire logic [7:0] fuse_high_out,
	input wire logic [7:0] fuse_ext_out,
	input wire logic [7:0] lock_bits_out
);
	// Erase sweep is the longest job
	localparam int BUSY_MAX = WRITE_TICKS + EEPROM_BYTES + PAGE_BYTES + 4;
	logic strobe_q;
	logic pulse_n_q;
	logic [7:0] cmd_q;
	logic [7:0] addr_lo_q;
	logic [18:0] prev_q;
	int busy_cnt_q;
	wire load_edge = load_strobe_clock_in && !strobe_q;
	wire [1:0] load_kind = {load_type_hi_in, load_type_lo_in};
	wire [18:0] view = {output_enable_n_in, byte_select_a_in, byte_select_b_in, cmd_q, addr_lo_q};
	// Read data lags one cycle, so only judge reads with inputs held
	wire settled = (view == prev_q) && !output_enable_n_in;
	wire is_write = cmd_q inside {CMD_CHIP_ERASE, CMD_WRITE_FUSE, CMD_WRITE_LOCK, CMD_WRITE_PROG,
		CMD_WRITE_EEPROM};
	wire starts = !write_pulse_n_in && pulse_n_q && ready_busy_flag_out && is_write
		&& !(cmd_q == CMD_WRITE_EEPROM && byte_select_a_in);
	wire [7:0] fuse_view = !byte_select_b_in ? (byte_select_a_in ? lock_bits_out : fuse_low_out)
		: (byte_select_a_in ? fuse_high_out : fuse_ext_out);
	wire [7:0] sig_view = addr_lo_q == 8'h00 ? SIG_BYTE0 : addr_lo_q == 8'h01 ? SIG_BYTE1 : SIG_BYTE2;
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			strobe_q <= 1'b0;
			pulse_n_q <= 1'b1;
			cmd_q <= CMD_NOP;
			addr_lo_q <= 8'h00;
			prev_q <= '1;
			busy_cnt_q <= 0;
		end else begin
			strobe_q <= load_strobe_clock_in;
			pulse_n_q <= write_pulse_n_in;
			if (load_edge && load_kind == LOAD_CMD) begin
				cmd_q <= data_in;
			end
			if (load_edge && load_kind == LOAD_ADDR && !byte_select_a_in) begin
				addr_lo_q <= data_in;
			end
			prev_q <= view;
			busy_cnt_q <= ready_busy_flag_out ? 0 : busy_cnt_q + 1;
		end
	end
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (srst_in);
	a_oe_follows: assert property (data_oe_out == !output_enable_n_in)
		else $error("data enable does not follow output enable");
	a_busy_start: assert property (starts |=> !ready_busy_flag_out)
		else $error("write pulse did not start a job");
	a_busy_hold: assert property ($fell(ready_busy_flag_out) |-> !ready_busy_flag_out[*8])
		else $error("busy released too early");
	a_busy_bound: assert property (busy_cnt_q <= BUSY_MAX)
		else $error("busy lasted too long");
	a_fuse_map: assert property (settled && cmd_q == CMD_READ_FUSE |-> data_out == fuse_view)
		else $error("fuse or lock read wrong byte");
	a_sig_read: assert property (settled && cmd_q == CMD_READ_SIG && !byte_select_a_in
		&& addr_lo_q <= SIG_MAX_ADDR |-> data_out == sig_view)
		else $error("signature byte wrong");
	a_cal_read: assert property (settled && cmd_q == CMD_READ_SIG && byte_select_a_in
		&& addr_lo_q == 8'h00 |-> data_out == CALIBRATION)
		else $error("calibration byte wrong");
	a_lock_no_clear: assert property (|(lock_bits_out & ~$past(lock_bits_out))
		|-> cmd_q == CMD_CHIP_ERASE)
		else $error("lock bit cleared without erase");
	a_boot_guard: assert property ($past(lock_bits_out[1:0]) == 2'b00
		|-> ($past(lock_bits_out) & ~lock_bits_out & BOOT_LOCK_MASK) == 8'h00)
		else $error("boot lock programmed in mode 3");
	a_fuse_quiet: assert property ($changed({fuse_low_out, fuse_high_out, fuse_ext_out})
		|-> cmd_q == CMD_WRITE_FUSE)
		else $error("fuses changed outside fuse write");
	c_eeprom_job: cover property (starts && cmd_q == CMD_WRITE_EEPROM);
	c_erase_job: cover property (starts && cmd_q == CMD_CHIP_ERASE);
	c_prog_job: cover property (starts && cmd_q == CMD_WRITE_PROG);
	c_lock_mode3: cover property (lock_bits_out[1:0] == 2'b00);
endmodule : nvm_port_properties
`default_nettype wire

// File: dv/nvm_programmer.sv
/* Behavioural external programmer driving the parallel pins.
   Assumes the bench resolves the data bus from the port's enable. */
`default_nettype none
module nvm_programmer
	import nvm_port_pkg::*;
(
	input wire logic clock_in,
	input wire logic ready_in,
	input wire logic [7:0] bus_in,
	output logic strobe_out = 1'b0,
	output logic type_hi_out = 1'b1,
	output logic type_lo_out = 1'b1,
	output logic sel_a_out = 1'b0,
	output logic sel_b_out = 1'b0,
	output logic latch_out = 1'b0,
	output logic pulse_n_out = 1'b1,
	output logic oe_n_out = 1'b1,
	output logic [7:0] data_out = 8'h00
);
	timeunit 1ns;
	timeprecision 1ns;
	task automatic step();
		@(posedge clock_in);
		#2;
	endtask : step
	task automatic load(input logic [1:0] kind, input logic sel_a, input logic [7:0] value);
		{type_hi_out, type_lo_out} = kind;
		sel_a_out = sel_a;
		data_out = value;
		strobe_out = 1'b1;
		step();
		strobe_out = 1'b0;
		{type_hi_out, type_lo_out} = 2'b11;
		// Released bus shows the inverse, not a stale copy
		data_out = ~value;
		step();
	endtask : load
	task automatic latch();
		latch_out = 1'b1;
		step();
		latch_out = 1'b0;
		step();
	endtask : latch
	task automatic pulse(input logic sel_a, input logic sel_b);
		sel_a_out = sel_a;
		sel_b_out = sel_b;
		step();
		pulse_n_out = 1'b0;
		step();
		pulse_n_out = 1'b1;
		step();
	endtask : pulse
	task automatic wait_ready();
		int n;
		n = 0;
		while (ready_in !== 1'b1 && n < 2000) begin
			step();
			n++;
		end
	endtask : wait_ready
	task automatic read(input logic sel_a, input logic sel_b, output logic [7:0] got);
		sel_a_out = sel_a;
		sel_b_out = sel_b;
		oe_n_out = 1'b0;
		step();
		step();
		got = bus_in;
		oe_n_out = 1'b1;
		step();
	endtask : read
endmodule : nvm_programmer
`default_nettype wire

// File: dv/tb_top.sv
/* Self-checking bench for the parallel programming port.
   Assumes shortened sizes and write time; the programmer model drives all pins except clock and reset. */
`default_nettype none
module tb_top
	import nvm_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// Identity values are arbitrary
	localparam logic [7:0] SIG0 = 8'h11;
	localparam logic [7:0] SIG1 = 8'h22;
	localparam logic [7:0] SIG2 = 8'h33;
	localparam logic [7:0] CAL = 8'h6E;
	// Shortened self-timed write length for simulation
	localparam int TICKS = 10;
	logic clock_in = 1'b0;
	logic srst_in = 1'b1;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	wire strobe, kind_hi, kind_lo, sel_a, sel_b, latch, pulse_n, oe_n, oe, ready;
	wire [7:0] prog_data, dev_data, fuse_low, fuse_high, fuse_ext, lock_bits;
	wire [7:0] bus = oe ? dev_data : prog_data;
	nvm_programmer prog (.clock_in(clock_in), .ready_in(ready), .bus_in(bus),
		.strobe_out(strobe), .type_hi_out(kind_hi), .type_lo_out(kind_lo), .sel_a_out(sel_a),
		.sel_b_out(sel_b), .latch_out(latch), .pulse_n_out(pulse_n), .oe_n_out(oe_n),
		.data_out(prog_data));
	nvm_prog_port #(.PROG_WORDS(256), .EEPROM_BYTES(64), .WRITE_TICKS(TICKS), .SIG_BYTE0(SIG0),
		.SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2), .CALIBRATION(CAL)) dut (.clock_in(clock_in),
		.srst_in(srst_in), .load_strobe_clock_in(strobe), .load_type_hi_in(kind_hi),
		.load_type_lo_in(kind_lo), .byte_select_a_in(sel_a), .byte_select_b_in(sel_b),
		.page_latch_strobe_in(latch), .write_pulse_n_in(pulse_n), .output_enable_n_in(oe_n),
		.data_in(bus), .data_out(dev_data), .data_oe_out(oe), .ready_busy_flag_out(ready),
		.fuse_low_out(fuse_low), .fuse_high_out(fuse_high), .fuse_ext_out(fuse_ext),
		.lock_bits_out(lock_bits));
	initial begin
		forever #10 clock_in = ~clock_in;
	end
	task automatic print_verdict();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : print_verdict
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			print_verdict();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic a, input logic b, input logic [7:0] exp);
		logic [7:0] got;
		prog.read(a, b, got);
		chk(got, exp);
	endtask : rd
	task automatic addr(input logic [7:0] hi, input logic [7:0] lo);
		prog.load(LOAD_ADDR, 1'b1, hi);
		prog.load(LOAD_ADDR, 1'b0, lo);
	endtask : addr
	task automatic job(input logic a, input logic b);
		prog.pulse(a, b);
		chk({7'h00, ready}, 8'h00);
		prog.wait_ready();
		chk({7'h00, ready}, 8'h01);
	endtask : job
	task automatic sig_scan();
		prog.load(LOAD_CMD, 1'b0, CMD_READ_SIG);
		for (int i = 0; i < 3; i++) begin
			prog.load(LOAD_ADDR, 1'b0, 8'(i));
			rd(1'b0, 1'b0, i == 0 ? SIG0 : i == 1 ? SIG1 : SIG2);
		end
		prog.load(LOAD_ADDR, 1'b0, 8'h00);
		rd(1'b1, 1'b0, CAL);
	endtask : sig_scan
	task automatic fuse_cycle();
		logic [7:0] val [3] = '{8'hA5, 8'h3C, 8'hF0};
		prog.load(LOAD_CMD, 1'b0, CMD_WRITE_FUSE);
		for (int i = 0; i < 3; i++) begin
			prog.load(LOAD_DATA, 1'b0, val[i]);
			job(i == 1, i == 2);
		end
		chk(fuse_low, val[0]);
		chk(fuse_high, val[1]);
		chk(fuse_ext, val[2]);
		prog.load(LOAD_CMD, 1'b0, CMD_READ_FUSE);
		rd(1'b0, 1'b0, val[0]);
		rd(1'b1, 1'b1, val[1]);
		rd(1'b0, 1'b1, val[2]);
		rd(1'b1, 1'b0, LOCK_RESET);
	endtask : fuse_cycle
	task automatic erase_all();
		prog.load(LOAD_CMD, 1'b0, CMD_CHIP_ERASE);
		job(1'b0, 1'b0);
		chk(lock_bits, LOCK_RESET);
		prog.load(LOAD_CMD, 1'b0, CMD_READ_EEPROM);
		addr(8'h00, 8'h08);
		rd(1'b0, 1'b0, ERASED_BYTE);
		prog.load(LOAD_CMD, 1'b0, CMD_READ_PROG);
		addr(8'h00, 8'hFF);
		rd(1'b0, 1'b0, ERASED_BYTE);
		rd(1'b1, 1'b0, ERASED_BYTE);
	endtask : erase_all
	task automatic eeprom_page();
		prog.load(LOAD_CMD, 1'b0, CMD_WRITE_EEPROM);
		prog.load(LOAD_ADDR, 1'b1, 8'h00);
		for (int i = 0; i < 2; i++) begin
			prog.load(LOAD_ADDR, 1'b0, 8'(8 + i));
			prog.load(LOAD_DATA, 1'b0, 8'(8'hC0 + i));
			prog.latch();
		end
		// Select A high must not start the page
		prog.pulse(1'b1, 1'b0);
		chk({7'h00, ready}, 8'h01);
		job(1'b0, 1'b0);
		prog.load(LOAD_CMD, 1'b0, CMD_READ_EEPROM);
		addr(8'h00, 8'h08);
		rd(1'b0, 1'b0, 8'hC0);
		prog.load(LOAD_ADDR, 1'b0, 8'h09);
		rd(1'b0, 1'b0, 8'hC1);
		prog.load(LOAD_ADDR, 1'b0, 8'h0A);
		rd(1'b0, 1'b0, ERASED_BYTE);
	endtask : eeprom_page
	task automatic prog_page();
		prog.load(LOAD_CMD, 1'b0, CMD_WRITE_PROG);
		prog.load(LOAD_ADDR, 1'b0, 8'h85);
		prog.load(LOAD_DATA, 1'b0, 8'h34);
		prog.load(LOAD_DATA, 1'b1, 8'h12);
		prog.latch();
		prog.load(LOAD_ADDR, 1'b1, 8'h00);
		prog.pulse(1'b0, 1'b0);
		// Pulse while busy must not restart the timed write
		prog.pulse(1'b0, 1'b0);
		repeat (TICKS - 5) prog.step();
		chk({7'h00, ready}, 8'h00);
		prog.step();
		chk({7'h00, ready}, 8'h01);
		prog.load(LOAD_CMD, 1'b0, CMD_READ_PROG);
		rd(1'b0, 1'b0, 8'h34);
		rd(1'b1, 1'b0, 8'h12);
	endtask : prog_page
	task automatic lock_rules();
		logic [7:0] val [3] = '{8'hFC, 8'h00, 8'hFF};
		logic [7:0] exp [3] = '{8'hFC, 8'h3C, 8'h3C};
		prog.load(LOAD_CMD, 1'b0, CMD_WRITE_LOCK);
		for (int i = 0; i < 3; i++) begin
			prog.load(LOAD_DATA, 1'b0, val[i]);
			job(1'b0, 1'b0);
			chk(lock_bits, exp[i]);
		end
		prog.load(LOAD_CMD, 1'b0, CMD_READ_FUSE);
		rd(1'b1, 1'b0, 8'h3C);
	endtask : lock_rules
	initial begin
		repeat (12) @(posedge clock_in);
		#2;
		srst_in = 1'b0;
		prog.step();
		chk({7'h00, ready}, 8'h01);
		chk(lock_bits, LOCK_RESET);
		sig_scan();
		fuse_cycle();
		erase_all();
		eeprom_page();
		prog_page();
		lock_rules();
		erase_all();
		print_verdict();
	end
endmodule : tb_top
bind nvm_prog_port nvm_port_properties #(.WRITE_TICKS(WRITE_TICKS), .EEPROM_BYTES(EEPROM_BYTES),
	.PAGE_BYTES(PAGE_BYTES), .SIG_BYTE0(SIG_BYTE0), .SIG_BYTE1(SIG_BYTE1),
	.SIG_BYTE2(SIG_BYTE2), .CALIBRATION(CALIBRATION)) props (.clock_in(clock_in),
	.srst_in(srst_in), .load_strobe_clock_in(load_strobe_clock_in),
	.load_type_hi_in(load_type_hi_in), .load_type_lo_in(load_type_lo_in),
	.byte_select_a_in(byte_select_a_in), .byte_select_b_in(byte_select_b_in),
	.write_pulse_n_in(write_pulse_n_in), .output_enable_n_in(output_enable_n_in),
	.data_in(data_in), .data_out(data_out), .data_oe_out(data_oe_out),
	.ready_busy_flag_out(ready_busy_flag_out), .fuse_low_out(fuse_low_out),
	.fuse_high_out(fuse_high_out), .fuse_ext_out(fuse_ext_out), .lock_bits_out(lock_bits_out));
`default_nettype wire
